// ### design/rts_pkg.sv
package rts_pkg;
	localparam int unsigned ELEM_N       = 4;
	localparam int unsigned PHASE_N      = 3;
	localparam int unsigned INTER_N      = 8;
	localparam int unsigned IDX_A        = 0;
	localparam int unsigned IDX_B        = 1;
	localparam int unsigned IDX_C        = 2;
	localparam int unsigned IDX_FL       = 3;
	localparam int unsigned CLK_HZ       = 10_000_000;
	localparam int unsigned HOLD_TIME_MS = 3000;
	localparam int unsigned MS_PER_S     = 1000;
	localparam int unsigned HOLD_CYCLES  = (HOLD_TIME_MS * (CLK_HZ / MS_PER_S));
	localparam int unsigned CNT_W        = 25;
	localparam logic [ELEM_N-1:0]  ELEM_ZERO  = 4'h0;
	localparam logic [INTER_N-1:0] INTER_ZERO = 8'h00;
	localparam logic [CNT_W-1:0]   CNT_ZERO   = 25'h0000000;
	localparam logic [CNT_W-1:0]   CNT_ONE    = 25'h0000001;
endpackage

// ### design/rts_press_if.sv
interface rts_press_if;
	logic btn_level;
	logic reset_pulse;
	modport timer (input btn_level, output reset_pulse);
	modport core (output btn_level, input reset_pulse);
endinterface

// ### design/rts_press_timer.sv
module rts_press_timer #(
	parameter int unsigned HOLD_CYCLES = rts_pkg::HOLD_CYCLES
) (
	// Clock and control
	input wire logic      clk_sys,
	input wire logic      rst,
	input wire logic      ce,
	// Button level and reset pulse
	rts_press_if.timer    press
);
	localparam logic [rts_pkg::CNT_W-1:0] HOLD_LIMIT = HOLD_CYCLES[rts_pkg::CNT_W-1:0];

	logic [rts_pkg::CNT_W-1:0] count_q, count_d;
	logic                      fired_q, fired_d;
	logic                      pulse_q, pulse_d;

	always_comb begin
		count_d = count_q;
		fired_d = fired_q;
		pulse_d = 1'b0;
		if (!press.btn_level) begin
			// Release rearms; a short hold never reaches the limit
			count_d = rts_pkg::CNT_ZERO;
			fired_d = 1'b0;
		end else if (!fired_q) begin
			if (count_q == HOLD_LIMIT) begin
				// Held one cycle beyond the full time, so strictly longer
				pulse_d = 1'b1;
				fired_d = 1'b1;
			end else begin
				count_d = count_q + rts_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_q <= rts_pkg::CNT_ZERO;
			fired_q <= 1'b0;
			pulse_q <= 1'b0;
		end else if (ce) begin
			count_q <= count_d;
			fired_q <= fired_d;
			pulse_q <= pulse_d;
		end
	end

	assign press.reset_pulse = pulse_q;

	single_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && pulse_q) |=> !pulse_q)
		else $error("reset pulse longer than one cycle");
	hold_needed_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && pulse_d) |-> (press.btn_level && count_q == HOLD_LIMIT))
		else $error("reset pulse without full hold");
endmodule

// ### design/rts_trip_logic.sv
module rts_trip_logic #(
	parameter int unsigned HOLD_CYCLES = rts_pkg::HOLD_CYCLES
) (
	// Clock and control
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        ce,
	// Differential elements
	input  wire logic                        phase_a_diff_detect,
	input  wire logic                        phase_b_diff_detect,
	input  wire logic                        phase_c_diff_detect,
	input  wire logic                        phase_a_diff_definitive,
	input  wire logic                        phase_b_diff_definitive,
	input  wire logic                        phase_c_diff_definitive,
	// Loss-of-field element
	input  wire logic                        field_loss_detect,
	input  wire logic                        field_loss_oc_detect,
	input  wire logic                        field_loss_definitive,
	// Operation locks
	input  wire logic                        phase_a_op_lock,
	input  wire logic                        phase_b_op_lock,
	input  wire logic                        phase_c_op_lock,
	input  wire logic                        field_loss_op_lock,
	// Differential-current supervision
	input  wire logic                        phase_a_superv_detect,
	input  wire logic                        phase_b_superv_detect,
	input  wire logic                        phase_c_superv_detect,
	input  wire logic                        phase_a_superv_definitive,
	input  wire logic                        phase_b_superv_definitive,
	input  wire logic                        phase_c_superv_definitive,
	// Forced operation, constant supervision, logic equations
	input  wire logic [rts_pkg::ELEM_N-1:0]  force_operate,
	input  wire logic                        serious_fault_in,
	input  wire logic                        minor_fault_in,
	input  wire logic [rts_pkg::INTER_N-1:0] logic_intermediate_in,
	// Front panel pin
	input  wire logic                        escape_clear_button,
	// Trip outputs
	output logic                             phase_a_diff_trip,
	output logic                             phase_b_diff_trip,
	output logic                             phase_c_diff_trip,
	output logic                             field_loss_trip,
	output logic                             phase_a_trip_latched,
	output logic                             phase_b_trip_latched,
	output logic                             phase_c_trip_latched,
	output logic                             field_loss_trip_latched,
	// Aggregates
	output logic                             any_phase_trip_out,
	output logic                             any_phase_detect_out,
	output logic                             any_superv_detect_out,
	output logic                             any_superv_definitive_out,
	output logic                             all_elements_detect_out,
	output logic                             all_elements_trip_out,
	// Operated outputs
	output logic                             phase_a_operated_out,
	output logic                             phase_b_operated_out,
	output logic                             phase_c_operated_out,
	output logic                             field_loss_operated_out,
	// Supervision stages, alarms, intermediates, reset
	output logic [rts_pkg::PHASE_N-1:0]      superv_detect_out,
	output logic [rts_pkg::PHASE_N-1:0]      superv_definitive_out,
	output logic                             serious_fault_alarm,
	output logic                             minor_fault_alarm,
	output logic [rts_pkg::INTER_N-1:0]      logic_intermediate,
	output logic                             escape_clear_reset
);
	rts_press_if press ();

	logic [rts_pkg::ELEM_N-1:0]  defin_c, lock_c, trip_c, oper_c;
	logic [rts_pkg::ELEM_N-1:0]  trip_q, trip_d, latch_q, latch_d, oper_q, oper_d;
	logic [rts_pkg::PHASE_N-1:0] sdet_c, sdef_c, sdet_q, sdet_d, sdef_q, sdef_d;
	logic                        det_all_c;
	logic                        anyd_q, anyd_d, alld_q, alld_d;
	logic                        ser_q, ser_d, min_q, min_d;
	logic [rts_pkg::INTER_N-1:0] inter_q, inter_d;
	logic                        btn_s1_q, btn_s2_q, btn_s3_q, btn_lvl_q;
	logic                        btn_s1_d, btn_s2_d, btn_s3_d, btn_lvl_d;

	// Element inputs come from logic on this clock, so no synchroniser
	always_comb begin
		defin_c = {field_loss_definitive, phase_c_diff_definitive,
			phase_b_diff_definitive, phase_a_diff_definitive};
		lock_c  = {field_loss_op_lock, phase_c_op_lock, phase_b_op_lock, phase_a_op_lock};
		trip_c  = defin_c & lock_c;
		oper_c  = trip_c | force_operate;
		sdet_c  = {phase_c_superv_detect, phase_b_superv_detect, phase_a_superv_detect};
		sdef_c  = {phase_c_superv_definitive, phase_b_superv_definitive,
			phase_a_superv_definitive};
		det_all_c = phase_a_diff_detect | phase_b_diff_detect | phase_c_diff_detect
			| field_loss_detect | field_loss_oc_detect;
	end

	always_comb begin
		trip_d  = trip_c;
		oper_d  = oper_c;
		sdet_d  = sdet_c;
		sdef_d  = sdef_c;
		anyd_d  = phase_a_diff_detect | phase_b_diff_detect | phase_c_diff_detect;
		alld_d  = det_all_c;
		ser_d   = serious_fault_in;
		min_d   = minor_fault_in;
		inter_d = logic_intermediate_in;
		// Clear beats set so a standing trip cannot mask the panel reset
		if (press.reset_pulse)
			latch_d = rts_pkg::ELEM_ZERO;
		else
			latch_d = latch_q | trip_c;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trip_q  <= rts_pkg::ELEM_ZERO;
			latch_q <= rts_pkg::ELEM_ZERO;
			oper_q  <= rts_pkg::ELEM_ZERO;
			sdet_q  <= '0;
			sdef_q  <= '0;
			anyd_q  <= 1'b0;
			alld_q  <= 1'b0;
			ser_q   <= 1'b0;
			min_q   <= 1'b0;
			inter_q <= rts_pkg::INTER_ZERO;
		end else if (ce) begin
			trip_q  <= trip_d;
			latch_q <= latch_d;
			oper_q  <= oper_d;
			sdet_q  <= sdet_d;
			sdef_q  <= sdef_d;
			anyd_q  <= anyd_d;
			alld_q  <= alld_d;
			ser_q   <= ser_d;
			min_q   <= min_d;
			inter_q <= inter_d;
		end
	end

	// Button pin: third stage filters a metastable second stage
	always_comb begin
		btn_s1_d  = escape_clear_button;
		btn_s2_d  = btn_s1_q;
		btn_s3_d  = btn_s2_q;
		btn_lvl_d = (btn_s2_q == btn_s3_q) ? btn_s3_q : btn_lvl_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			btn_s1_q  <= 1'b0;
			btn_s2_q  <= 1'b0;
			btn_s3_q  <= 1'b0;
			btn_lvl_q <= 1'b0;
		end else if (ce) begin
			btn_s1_q  <= btn_s1_d;
			btn_s2_q  <= btn_s2_d;
			btn_s3_q  <= btn_s3_d;
			btn_lvl_q <= btn_lvl_d;
		end
	end

	assign press.btn_level = btn_lvl_q;

	rts_press_timer #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_press (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.press   (press.timer)
	);

	assign phase_a_diff_trip         = trip_q[rts_pkg::IDX_A];
	assign phase_b_diff_trip         = trip_q[rts_pkg::IDX_B];
	assign phase_c_diff_trip         = trip_q[rts_pkg::IDX_C];
	assign field_loss_trip           = trip_q[rts_pkg::IDX_FL];
	assign phase_a_trip_latched      = latch_q[rts_pkg::IDX_A];
	assign phase_b_trip_latched      = latch_q[rts_pkg::IDX_B];
	assign phase_c_trip_latched      = latch_q[rts_pkg::IDX_C];
	assign field_loss_trip_latched   = latch_q[rts_pkg::IDX_FL];
	assign any_phase_trip_out        = |trip_q[rts_pkg::IDX_C:rts_pkg::IDX_A];
	assign any_phase_detect_out      = anyd_q;
	assign any_superv_detect_out     = |sdet_q;
	assign any_superv_definitive_out = |sdef_q;
	assign all_elements_detect_out   = alld_q;
	assign all_elements_trip_out     = |trip_q;
	assign phase_a_operated_out      = oper_q[rts_pkg::IDX_A];
	assign phase_b_operated_out      = oper_q[rts_pkg::IDX_B];
	assign phase_c_operated_out      = oper_q[rts_pkg::IDX_C];
	assign field_loss_operated_out   = oper_q[rts_pkg::IDX_FL];
	assign superv_detect_out         = sdet_q;
	assign superv_definitive_out     = sdef_q;
	assign serious_fault_alarm       = ser_q;
	assign minor_fault_alarm         = min_q;
	assign logic_intermediate        = inter_q;
	assign escape_clear_reset        = press.reset_pulse;

	trip_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (trip_q == $past(trip_c)))
		else $error("trip not equal to gated definitive");
	phase_or_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (any_phase_trip_out == $past((phase_a_diff_definitive & phase_a_op_lock)
			| (phase_b_diff_definitive & phase_b_op_lock) | (phase_c_diff_definitive & phase_c_op_lock))))
		else $error("three-phase trip mismatch");
	phase_detect_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (any_phase_detect_out == $past(phase_a_diff_detect | phase_b_diff_detect | phase_c_diff_detect)))
		else $error("combined differential detection mismatch");
	superv_detect_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (any_superv_detect_out == $past(phase_a_superv_detect | phase_b_superv_detect | phase_c_superv_detect)))
		else $error("combined supervision detection mismatch");
	superv_defin_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (any_superv_definitive_out == $past(phase_a_superv_definitive | phase_b_superv_definitive
			| phase_c_superv_definitive)))
		else $error("combined supervision definitive mismatch");
	all_trip_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (all_elements_trip_out == |$past(trip_c)))
		else $error("all-elements trip mismatch");
	all_detect_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (all_elements_detect_out == $past(det_all_c)))
		else $error("all-elements detection mismatch");
	operated_a: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> (oper_q == $past(oper_c)))
		else $error("operated output mismatch");
	latch_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && !press.reset_pulse) |=> ((latch_q & $past(latch_q)) == $past(latch_q)))
		else $error("latched trip dropped without reset");
	latch_set_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && !press.reset_pulse) |=> ((latch_q & $past(trip_c)) == $past(trip_c)))
		else $error("latched trip missed its source");
	latch_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && press.reset_pulse) |=> (latch_q == rts_pkg::ELEM_ZERO))
		else $error("latched trips not cleared by reset");
endmodule

// ### bench/rts_elem_model.sv
module rts_elem_model (
	// Clock
	input  wire logic        clk_sys,
	// Element levels and press request
	input  wire logic [20:0] lvl,
	input  wire logic [7:0]  press_len,
	input  wire logic        press_go,
	// Toward the trip logic
	output logic      [20:0] elem,
	output logic             button
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left_q = 8'h00;
	assign elem = lvl;
	// Clean press of exactly press_len cycles, no bounce
	assign button = (left_q != 8'h00);
	always @(posedge clk_sys) begin
		if (press_go)
			left_q <= press_len;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
endmodule

// ### bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned HOLD = 4;
	logic        clk_sys, rst, ce, press_go, button, rst_pulse, ser, mnr;
	logic [20:0] lvl, elem;
	logic [7:0]  press_len, inter_i, inter_o;
	logic [3:0]  force_op, trip, latch, oper, exp_l;
	logic [5:0]  agg;
	logic [2:0]  sdet, sdef;
	logic [33:0] exp_o;
	int          num_errors, compares;

	rts_elem_model u_elem (.clk_sys(clk_sys), .lvl(lvl), .press_len(press_len), .press_go(press_go),
		.elem(elem), .button(button));

	rts_trip_logic #(.HOLD_CYCLES(HOLD)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.phase_a_diff_detect(elem[0]), .phase_b_diff_detect(elem[1]), .phase_c_diff_detect(elem[2]),
		.phase_a_diff_definitive(elem[3]), .phase_b_diff_definitive(elem[4]), .phase_c_diff_definitive(elem[5]),
		.field_loss_detect(elem[6]), .field_loss_oc_detect(elem[7]), .field_loss_definitive(elem[8]),
		.phase_a_op_lock(elem[9]), .phase_b_op_lock(elem[10]), .phase_c_op_lock(elem[11]),
		.field_loss_op_lock(elem[12]), .phase_a_superv_detect(elem[13]), .phase_b_superv_detect(elem[14]),
		.phase_c_superv_detect(elem[15]), .phase_a_superv_definitive(elem[16]),
		.phase_b_superv_definitive(elem[17]), .phase_c_superv_definitive(elem[18]),
		.force_operate(force_op), .serious_fault_in(elem[19]), .minor_fault_in(elem[20]),
		.logic_intermediate_in(inter_i), .escape_clear_button(button),
		.phase_a_diff_trip(trip[0]), .phase_b_diff_trip(trip[1]), .phase_c_diff_trip(trip[2]),
		.field_loss_trip(trip[3]), .phase_a_trip_latched(latch[0]), .phase_b_trip_latched(latch[1]),
		.phase_c_trip_latched(latch[2]), .field_loss_trip_latched(latch[3]),
		.any_phase_trip_out(agg[0]), .any_phase_detect_out(agg[1]), .any_superv_detect_out(agg[2]),
		.any_superv_definitive_out(agg[3]), .all_elements_detect_out(agg[4]), .all_elements_trip_out(agg[5]),
		.phase_a_operated_out(oper[0]), .phase_b_operated_out(oper[1]), .phase_c_operated_out(oper[2]),
		.field_loss_operated_out(oper[3]), .superv_detect_out(sdet), .superv_definitive_out(sdef),
		.serious_fault_alarm(ser), .minor_fault_alarm(mnr), .logic_intermediate(inter_o),
		.escape_clear_reset(rst_pulse));

	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		compares++;
		if (got !== want) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	// Expectation from inputs seen at the coming edge; clear beats set
	task automatic step;
		logic [3:0] g;
		g = {elem[8], elem[5:3]} & elem[12:9];
		if (rst) begin
			exp_l = 4'h0;
			exp_o = '0;
		end else if (ce) begin
			exp_l = (rst_pulse === 1'b1) ? 4'h0 : (exp_l | g);
			exp_o = {g, exp_l, g | force_op, |g, |{elem[2:0], elem[7:6]}, |elem[18:16], |elem[15:13],
				|elem[2:0], |g[2:0], elem[15:13], elem[18:16], elem[19], elem[20], inter_i};
		end
		@(posedge clk_sys);
		#1;
		chk({trip, latch, oper, agg, sdet, sdef, ser, mnr, inter_o}, exp_o);
	endtask

	task automatic t_gate;
		int e;
		logic [20:0] v;
		for (int k = 0; k < 16; k++) begin
			e = k / 4;
			v = '0;
			v[(e == 3) ? 8 : 3 + e] = k[0];
			v[9 + e] = k[1];
			lvl = v;
			force_op = (k % 4 == 2) ? (4'h1 << e) : 4'h0;
			step();
			lvl = '0;
			force_op = 4'h0;
			step();
		end
		$display("gate done");
	endtask

	task automatic t_walk;
		for (int i = 0; i < 21; i++) begin
			lvl = 21'h1 << i;
			inter_i = 8'h01 << (i % 8);
			step();
		end
		lvl = '0;
		inter_i = 8'h00;
		step();
		$display("walk done");
	endtask

	// Frozen while enable is low, then all latch at once
	task automatic t_freeze;
		ce = 1'b0;
		lvl = 21'h1fffff;
		force_op = 4'hf;
		repeat (3) step();
		ce = 1'b1;
		step();
		lvl = '0;
		force_op = 4'h0;
		step();
		rst = 1'b1;
		step();
		rst = 1'b0;
		step();
		$display("freeze and reset done");
	endtask

	task automatic t_press(input logic [7:0] len, input int want_at);
		int seen, at;
		seen = 0;
		at = 0;
		press_len = len;
		press_go = 1'b1;
		step();
		press_go = 1'b0;
		for (int n = 1; n <= 40; n++) begin
			step();
			if (rst_pulse === 1'b1) begin
				seen++;
				at = (seen > 1) ? 99 : n;
			end
		end
		chk(34'(at), 34'(want_at));
		$display("press %0d done", len);
	endtask

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// About 190 cycles expected; allow far more
	initial begin
		#500000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		lvl = '0;
		force_op = 4'h0;
		inter_i = 8'h00;
		press_go = 1'b0;
		press_len = 8'h00;
		num_errors = 0;
		compares = 0;
		exp_l = 4'h0;
		exp_o = '0;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_gate();
		t_walk();
		t_freeze();
		t_press(8'(HOLD), 0);
		lvl = 21'h000208;
		// Pulse seen HOLD+5 edges after load: four sync stages, then HOLD+1 counts
		t_press(8'(HOLD + 1), HOLD + 5);
		lvl = '0;
		t_press(8'h14, HOLD + 5);
		tally_and_finish();
	end
endmodule
